/* inc/dtf_pkg.sv */
// constants for the disk task-file register group
package dtf_pkg;
    // task-file port indices (low three address bits)
    localparam logic [2:0] ADDR_DATA   = 3'h0;
    localparam logic [2:0] ADDR_ERROR  = 3'h1;
    localparam logic [2:0] ADDR_COUNT  = 3'h2;
    localparam logic [2:0] ADDR_SECTOR = 3'h3;
    localparam logic [2:0] ADDR_CYL_LO = 3'h4;
    localparam logic [2:0] ADDR_CYL_HI = 3'h5;
    localparam logic [2:0] ADDR_HEAD   = 3'h6;
    localparam logic [2:0] ADDR_STATUS = 3'h7;

    // reset values
    localparam logic [7:0] RST_COUNT  = 8'h01;
    localparam logic [7:0] RST_SECTOR = 8'h01;
    localparam logic [7:0] RST_CYL    = 8'h00;
    localparam logic [7:0] RST_HEAD   = 8'h00;
    localparam logic [7:0] RST_ERROR  = 8'h01;

    // unit/head fields
    localparam int HEAD_FIXED_HI = 7;
    localparam int HEAD_LBA_BIT  = 6;
    localparam int HEAD_FIXED_LO = 5;
    localparam int HEAD_UNIT_BIT = 4;

    // status and error fields
    localparam int ST_BUSY_BIT  = 7;
    localparam int ST_READY_BIT = 6;
    localparam int ST_FAULT_BIT = 5;
    localparam int ST_SEEK_BIT  = 4;
    localparam int ST_XREQ_BIT  = 3;
    localparam int ST_ERR_BIT   = 0;
    localparam int ERR_ABORT_BIT = 2;

    // a stored count of zero stands for this many sectors
    localparam logic [8:0] FULL_COUNT = 9'h100;

    // opcodes
    localparam logic [7:0] OP_WR_NORM    = 8'h30;
    localparam logic [7:0] OP_WR_NORM_NR = 8'h31;
    localparam logic [7:0] OP_WR_LONG    = 8'h32;
    localparam logic [7:0] OP_WR_LONG_NR = 8'h33;
    localparam logic [7:0] OP_WR_VERIFY  = 8'h3C;
    localparam logic [7:0] OP_WR_BUFFER  = 8'hE8;
    localparam logic [7:0] OP_WR_MULTI   = 8'hC5;
    localparam logic [7:0] OP_WR_DMA     = 8'hCA;
    localparam logic [7:0] OP_WR_DMA_NR  = 8'hCB;
    localparam logic [7:0] OP_RD_BUFFER  = 8'hE4;
    localparam logic [7:0] OP_RD_MULTI   = 8'hC4;
    localparam logic [7:0] OP_SET_FEAT   = 8'hEF;
    localparam logic [7:0] OP_SET_MULTI  = 8'hC6;
    localparam logic [7:0] OP_RD_NATIVE  = 8'hF8;
    localparam logic [7:0] OP_SET_MAX    = 8'hF9;
    localparam logic [7:0] OP_IDENTIFY   = 8'hEC;
    localparam logic [7:0] OP_INIT_PARAM = 8'h91;
    localparam logic [7:0] OP_FORMAT     = 8'h50;
    localparam logic [7:0] OP_DIAG       = 8'h90;
    localparam logic [7:0] OP_MONITOR    = 8'hB0;
    localparam logic [3:0] OP_RECAL_HI   = 4'h1;
    localparam logic [3:0] OP_SEEK_HI    = 4'h7;
    localparam logic [6:0] OP_RD_SECT_HI = 7'h10;  // 20h..23h
    localparam logic [6:0] OP_RD_VER_HI  = 7'h20;  // 40h..41h
    localparam logic [6:0] OP_RD_DMA_HI  = 7'h64;  // C8h..C9h
    localparam logic [7:0] OP_PWR_ALT_LO = 8'h94;  // 94h..99h
    localparam logic [7:0] OP_PWR_ALT_HI = 8'h99;
    localparam logic [7:0] OP_PWR_LO     = 8'hE0;  // E0h..E3h, E5h, E6h
    localparam logic [7:0] OP_PWR_HI     = 8'hE6;
    localparam logic [7:0] OP_PWR_GAP    = 8'hE4;
endpackage : dtf_pkg

/* hw/dtf_task_file.sv */
// task-file register group: parameters, status and command of a disk unit
`timescale 1ns/1ps
module dtf_task_file (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_cs,
    input  wire logic [2:0]  i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    input  wire logic        i_init_done,
    input  wire logic        i_unit_ready_flag,
    input  wire logic        i_write_fault_flag,
    input  wire logic        i_seek_done_flag,
    input  wire logic        i_transfer_request_flag,
    input  wire logic        i_sector_done,
    input  wire logic        i_cmd_done,
    input  wire logic        i_cmd_error,
    output logic             o_busy,
    output logic             o_irq,
    output logic             o_cmd_start,
    output logic      [7:0]  o_cmd_opcode,
    output logic      [8:0]  o_transfer_total,
    output logic      [27:0] o_lba_addr,
    output logic             o_linear_block_mode,
    output logic             o_unit_select,
    output logic      [3:0]  o_head
);

    typedef enum logic [2:0] {
        DTF_INIT = 3'b001,
        DTF_IDLE = 3'b010,
        DTF_EXEC = 3'b100
    } dtf_state_t;

    dtf_state_t  state_reg, state_next;
    logic [7:0]  count_reg, count_next;
    logic [7:0]  sector_reg, sector_next;
    logic [7:0]  cyl_lo_reg, cyl_lo_next;
    logic [7:0]  cyl_hi_reg, cyl_hi_next;
    logic [5:0]  head_reg, head_next;     // {lba, unit, head[3:0]}
    logic [7:0]  opcode_reg;
    logic        err_reg, err_next;
    logic        abort_reg, abort_next;
    logic        diag_reg;
    logic        irq_reg, irq_next;
    logic        start_reg;
    logic [7:0]  rdata_reg, rdata_next;

    // opcode is a known command
    function automatic logic dtf_valid(input logic [7:0] op);
        logic v;
        v = 1'b0;
        unique case (op)
            dtf_pkg::OP_WR_NORM, dtf_pkg::OP_WR_NORM_NR,
            dtf_pkg::OP_WR_LONG, dtf_pkg::OP_WR_LONG_NR,
            dtf_pkg::OP_WR_VERIFY, dtf_pkg::OP_WR_BUFFER,
            dtf_pkg::OP_WR_MULTI, dtf_pkg::OP_WR_DMA,
            dtf_pkg::OP_WR_DMA_NR: v = 1'b1;
            dtf_pkg::OP_SET_FEAT, dtf_pkg::OP_SET_MULTI,
            dtf_pkg::OP_RD_NATIVE, dtf_pkg::OP_SET_MAX: v = 1'b1;
            dtf_pkg::OP_IDENTIFY, dtf_pkg::OP_INIT_PARAM,
            dtf_pkg::OP_FORMAT, dtf_pkg::OP_DIAG,
            dtf_pkg::OP_MONITOR, dtf_pkg::OP_RD_BUFFER,
            dtf_pkg::OP_RD_MULTI: v = 1'b1;
            default: v = 1'b0;
        endcase
        if (op[7:4] == dtf_pkg::OP_RECAL_HI || op[7:4] == dtf_pkg::OP_SEEK_HI) begin
            v = 1'b1;
        end
        if (op[7:2] == dtf_pkg::OP_RD_SECT_HI[6:1] || op[7:1] == dtf_pkg::OP_RD_VER_HI
            || op[7:1] == dtf_pkg::OP_RD_DMA_HI) begin
            v = 1'b1;
        end
        if ((op >= dtf_pkg::OP_PWR_ALT_LO && op <= dtf_pkg::OP_PWR_ALT_HI)
            || (op >= dtf_pkg::OP_PWR_LO && op <= dtf_pkg::OP_PWR_HI
                && op != dtf_pkg::OP_PWR_GAP)) begin
            v = 1'b1;
        end
        return v;
    endfunction : dtf_valid

    // command accepts linear addressing (uses the address registers)
    function automatic logic dtf_lba_ok(input logic [7:0] op);
        logic v;
        v = 1'b0;
        unique case (op)
            dtf_pkg::OP_WR_NORM, dtf_pkg::OP_WR_NORM_NR,
            dtf_pkg::OP_WR_LONG, dtf_pkg::OP_WR_LONG_NR,
            dtf_pkg::OP_WR_VERIFY, dtf_pkg::OP_WR_MULTI,
            dtf_pkg::OP_WR_DMA, dtf_pkg::OP_WR_DMA_NR,
            dtf_pkg::OP_RD_MULTI, dtf_pkg::OP_FORMAT,
            dtf_pkg::OP_INIT_PARAM, dtf_pkg::OP_RD_NATIVE,
            dtf_pkg::OP_SET_MAX: v = 1'b1;
            default: v = 1'b0;
        endcase
        if (op[7:4] == dtf_pkg::OP_SEEK_HI || op[7:2] == dtf_pkg::OP_RD_SECT_HI[6:1]
            || op[7:1] == dtf_pkg::OP_RD_VER_HI || op[7:1] == dtf_pkg::OP_RD_DMA_HI) begin
            v = 1'b1;
        end
        return v;
    endfunction : dtf_lba_ok

    // decode
    wire        idle       = (state_reg == DTF_IDLE);
    wire        exec       = (state_reg == DTF_EXEC);
    wire        busy       = !idle;
    wire        rd_hit     = i_cs && i_rd;
    wire        wr_hit     = i_cs && i_wr && idle;                // busy refuses writes
    wire        wr_count   = wr_hit && i_addr == dtf_pkg::ADDR_COUNT;
    wire        wr_sector  = wr_hit && i_addr == dtf_pkg::ADDR_SECTOR;
    wire        wr_cyl_lo  = wr_hit && i_addr == dtf_pkg::ADDR_CYL_LO;
    wire        wr_cyl_hi  = wr_hit && i_addr == dtf_pkg::ADDR_CYL_HI;
    wire        wr_head    = wr_hit && i_addr == dtf_pkg::ADDR_HEAD;
    wire        wr_cmd     = wr_hit && i_addr == dtf_pkg::ADDR_STATUS;
    wire        lba_on     = head_reg[5];
    wire        cmd_abort  = !dtf_valid(i_wdata)
                           || !i_unit_ready_flag || i_write_fault_flag
                           || (lba_on && !dtf_lba_ok(i_wdata));
    wire        cmd_accept = wr_cmd && !cmd_abort;
    wire        cmd_reject = wr_cmd && cmd_abort;
    wire        sect_step  = exec && i_sector_done;
    wire        finish     = exec && i_cmd_done;
    wire        stat_read  = rd_hit && i_addr == dtf_pkg::ADDR_STATUS;
    wire [27:0] lba_addr   = {head_reg[3:0], cyl_hi_reg, cyl_lo_reg, sector_reg};
    wire [27:0] lba_inc    = lba_addr + 28'h0000001;
    wire [7:0]  head_byte  = {1'b1, head_reg[5], 1'b1, head_reg[4:0]};
    wire [7:0]  err_byte   = {5'h00, abort_reg, 1'b0, diag_reg};

    wire [7:0] status_byte;
    assign status_byte[dtf_pkg::ST_BUSY_BIT]  = busy;
    assign status_byte[dtf_pkg::ST_READY_BIT] = i_unit_ready_flag;
    assign status_byte[dtf_pkg::ST_FAULT_BIT] = i_write_fault_flag;
    assign status_byte[dtf_pkg::ST_SEEK_BIT]  = i_seek_done_flag;
    assign status_byte[dtf_pkg::ST_XREQ_BIT]  = i_transfer_request_flag;
    assign status_byte[2:1]                   = 2'h0;
    assign status_byte[dtf_pkg::ST_ERR_BIT]   = err_reg;

    // read mux; busy overrides every register
    wire [7:0] reg_sel =
        (i_addr == dtf_pkg::ADDR_ERROR)  ? err_byte   :
        (i_addr == dtf_pkg::ADDR_COUNT)  ? count_reg  :
        (i_addr == dtf_pkg::ADDR_SECTOR) ? sector_reg :
        (i_addr == dtf_pkg::ADDR_CYL_LO) ? cyl_lo_reg :
        (i_addr == dtf_pkg::ADDR_CYL_HI) ? cyl_hi_reg :
        (i_addr == dtf_pkg::ADDR_HEAD)   ? head_byte  :
        (i_addr == dtf_pkg::ADDR_STATUS) ? status_byte : 8'h00;
    assign rdata_next = !rd_hit ? rdata_reg : (busy ? status_byte : reg_sel);

    // parameter registers
    assign count_next  = wr_count ? i_wdata : (sect_step ? count_reg - 8'h01 : count_reg);
    assign sector_next = wr_sector ? i_wdata :
                         (sect_step ? (lba_on ? lba_inc[7:0] : sector_reg + 8'h01)
                                    : sector_reg);
    assign cyl_lo_next = wr_cyl_lo ? i_wdata :
                         ((sect_step && lba_on) ? lba_inc[15:8] : cyl_lo_reg);
    assign cyl_hi_next = wr_cyl_hi ? i_wdata :
                         ((sect_step && lba_on) ? lba_inc[23:16] : cyl_hi_reg);
    assign head_next   = wr_head ? {i_wdata[dtf_pkg::HEAD_LBA_BIT], i_wdata[4:0]} :
                         ((sect_step && lba_on) ? {head_reg[5:4], lba_inc[27:24]}
                                                : head_reg);

    // completion flags; a new event wins over any clear
    assign err_next   = (cmd_reject || (finish && i_cmd_error)) ? 1'b1 :
                        (cmd_accept ? 1'b0 : err_reg);
    assign abort_next = cmd_reject ? 1'b1 : (cmd_accept ? 1'b0 : abort_reg);
    assign irq_next   = (cmd_reject || finish) ? 1'b1 :
                        ((stat_read || cmd_accept) ? 1'b0 : irq_reg);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DTF_INIT: if (i_init_done) begin
                state_next = DTF_IDLE;
            end
            DTF_IDLE: if (cmd_accept) begin
                state_next = DTF_EXEC;
            end
            DTF_EXEC: if (i_cmd_done) begin
                state_next = DTF_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg  <= DTF_INIT;
            count_reg  <= dtf_pkg::RST_COUNT;
            sector_reg <= dtf_pkg::RST_SECTOR;
            cyl_lo_reg <= dtf_pkg::RST_CYL;
            cyl_hi_reg <= dtf_pkg::RST_CYL;
            head_reg   <= dtf_pkg::RST_HEAD[5:0];
            err_reg    <= 1'b0;
            abort_reg  <= 1'b0;
            diag_reg   <= dtf_pkg::RST_ERROR[0];
            irq_reg    <= 1'b0;
            start_reg  <= 1'b0;
            opcode_reg <= 8'h00;
            rdata_reg  <= 8'h00;
        end else begin
            state_reg  <= state_next;
            count_reg  <= count_next;
            sector_reg <= sector_next;
            cyl_lo_reg <= cyl_lo_next;
            cyl_hi_reg <= cyl_hi_next;
            head_reg   <= head_next;
            err_reg    <= err_next;
            abort_reg  <= abort_next;
            diag_reg   <= wr_cmd ? 1'b0 : diag_reg;
            irq_reg    <= irq_next;
            start_reg  <= cmd_accept;
            opcode_reg <= wr_cmd ? i_wdata : opcode_reg;
            rdata_reg  <= rdata_next;
        end
    end

    assign o_rdata             = rdata_reg;
    assign o_busy              = busy;
    assign o_irq               = irq_reg;
    assign o_cmd_start         = start_reg;
    assign o_cmd_opcode        = opcode_reg;
    assign o_transfer_total    = (count_reg == 8'h00) ? dtf_pkg::FULL_COUNT
                                                      : {1'b0, count_reg};
    assign o_lba_addr          = lba_addr;
    assign o_linear_block_mode = lba_on;
    assign o_unit_select       = head_reg[4];
    assign o_head              = head_reg[3:0];

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_reset_values;
        $past(i_rst) |-> busy && count_reg == 8'h01 && sector_reg == 8'h01
                         && cyl_lo_reg == 8'h00 && cyl_hi_reg == 8'h00 && !irq_reg;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

    property p_busy_read;
        rd_hit && busy |=> o_rdata == $past(status_byte);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy read not status");

    property p_status_clears_irq;
        stat_read && !finish && !cmd_reject |=> !o_irq;
    endproperty
    a_status_clears_irq: assert property (p_status_clears_irq) else $error("irq kept");

    property p_status_layout;
        rd_hit && i_addr == dtf_pkg::ADDR_STATUS |=> o_rdata[2:1] == 2'h0
            && o_rdata[7] == $past(busy) && o_rdata[0] == $past(err_reg);
    endproperty
    a_status_layout: assert property (p_status_layout) else $error("status layout");

    property p_cmd_start;
        cmd_accept |=> o_busy && o_cmd_start && !o_irq ##1 !o_cmd_start;
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("command not started");

    property p_abort;
        cmd_reject |=> !o_busy && err_reg && abort_reg && !o_cmd_start;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not reported");

    property p_abort_not_ready;
        wr_cmd && !i_unit_ready_flag |=> !o_busy && abort_reg;
    endproperty
    a_abort_not_ready: assert property (p_abort_not_ready) else $error("ran unready");

    property p_count_dec;
        sect_step |=> count_reg == $past(count_reg) - 8'h01;
    endproperty
    a_count_dec: assert property (p_count_dec) else $error("count not decremented");

    property p_sector_adv;
        sect_step && !lba_on |=> sector_reg == $past(sector_reg) + 8'h01;
    endproperty
    a_sector_adv: assert property (p_sector_adv) else $error("sector not advanced");

    property p_lba_adv;
        sect_step && lba_on |=> o_lba_addr == $past(o_lba_addr) + 28'h0000001;
    endproperty
    a_lba_adv: assert property (p_lba_adv) else $error("linear address not advanced");

    property p_zero_count;
        wr_count && i_wdata == 8'h00 |=> o_transfer_total == 9'h100;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("zero not 256");

    property p_head_fixed;
        rd_hit && idle && i_addr == dtf_pkg::ADDR_HEAD |=> o_rdata[7] && o_rdata[5];
    endproperty
    a_head_fixed: assert property (p_head_fixed) else $error("fixed bits low");

    property p_finish;
        finish |=> !o_busy && o_irq && err_reg == $past(i_cmd_error);
    endproperty
    a_finish: assert property (p_finish) else $error("completion wrong");

    property p_error_reset;
        $past(i_rst) |-> err_byte == dtf_pkg::RST_ERROR && head_byte == 8'hA0;
    endproperty
    a_error_reset: assert property (p_error_reset) else $error("error reset wrong");

    property p_busy_write_ignored;
        i_cs && i_wr && busy && i_addr == dtf_pkg::ADDR_COUNT && !sect_step
            |=> $stable(count_reg);
    endproperty
    a_busy_write_ignored: assert property (p_busy_write_ignored) else $error("busy write taken");

    c_accept: cover property (cmd_accept ##[1:20] finish);
    c_reject: cover property (cmd_reject);
    c_multi:  cover property (sect_step ##[1:20] sect_step);
    c_busy_rd: cover property (rd_hit && busy);
    c_lba_step: cover property (sect_step && lba_on);

endmodule : dtf_task_file

/* testbench/dtf_host_model.sv */
// host adapter model driving the task-file register port
`timescale 1ns/1ps
module dtf_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_cs,
    output logic [2:0]      o_addr,
    output logic            o_rd,
    output logic            o_wr,
    output logic [7:0]      o_wdata
);
    initial begin
        {o_cs, o_rd, o_wr, o_addr, o_wdata} = {3'h0, 3'h0, 8'h00};
    end

    // released address and data show the inverse of the last value
    task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {o_cs, o_wr, o_addr, o_wdata} <= {2'h3, a, d};
        @(posedge i_clk);
        {o_cs, o_wr, o_addr, o_wdata} <= {2'h0, ~a, ~d};
        #1;
    endtask : write_reg

    task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        {o_cs, o_rd, o_addr} <= {2'h3, a};
        @(posedge i_clk);
        {o_cs, o_rd, o_addr} <= {2'h0, ~a};
        #1;
        d = i_rdata;
    endtask : read_reg

    task automatic load(input logic [7:0] c, s, l, h, d);
        write_reg(3'h2, c);
        write_reg(3'h3, s);
        write_reg(3'h4, l);
        write_reg(3'h5, h);
        write_reg(3'h6, d);
    endtask : load

    // parameters always go out before the opcode
    task automatic command(input logic [7:0] c, s, l, h, d, op);
        load(c, s, l, h, d);
        write_reg(3'h7, op);
    endtask : command
endmodule : dtf_host_model

/* testbench/testbench.sv */
// self-checking bench for the disk task-file register group
`timescale 1ns/1ps
module testbench;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_cs, i_rd, i_wr;
    logic [2:0]  i_addr;
    logic [7:0]  i_wdata, o_rdata, o_cmd_opcode, rb;
    logic        i_init_done = 1'b0, i_unit_ready_flag = 1'b1, i_write_fault_flag = 1'b0;
    logic        i_seek_done_flag = 1'b0, i_transfer_request_flag = 1'b0;
    logic        i_sector_done = 1'b0, i_cmd_done = 1'b0, i_cmd_error = 1'b0;
    logic        o_busy, o_irq, o_cmd_start, o_linear_block_mode, o_unit_select;
    logic [3:0]  o_head;
    logic [8:0]  o_transfer_total;
    logic [27:0] o_lba_addr;
    int          miscompares = 0, tests_run = 0, cycles = 0, seed, la;
    int          cnt = 1, sec = 1, clo = 0, chi = 0, hd = 0;
    logic        m_busy = 1'b1, m_irq = 1'b0, m_err = 1'b0, m_abrt = 1'b0;
    logic [7:0]  good_ops [$] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h3C, 8'hE8, 8'hC5, 8'hCA,
        8'hCB, 8'hEF, 8'hC6, 8'hF8, 8'hF9, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'hE0,
        8'hE1, 8'hE2, 8'hE3, 8'hE5, 8'hE6, 8'hEC, 8'h91, 8'h1A, 8'h7F, 8'h50, 8'h90, 8'hB0};
    logic [7:0]  bad_ops [$] = '{8'h00, 8'hE7, 8'hFF, 8'hA5};

    always #50 i_clk = ~i_clk;

    dtf_task_file dtf_task_file_inst (.i_clk(i_clk), .i_rst(i_rst), .i_cs(i_cs),
        .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .i_init_done(i_init_done), .i_unit_ready_flag(i_unit_ready_flag),
        .i_write_fault_flag(i_write_fault_flag), .i_seek_done_flag(i_seek_done_flag),
        .i_transfer_request_flag(i_transfer_request_flag), .i_sector_done(i_sector_done),
        .i_cmd_done(i_cmd_done), .i_cmd_error(i_cmd_error), .o_busy(o_busy), .o_irq(o_irq),
        .o_cmd_start(o_cmd_start), .o_cmd_opcode(o_cmd_opcode),
        .o_transfer_total(o_transfer_total), .o_lba_addr(o_lba_addr),
        .o_linear_block_mode(o_linear_block_mode), .o_unit_select(o_unit_select),
        .o_head(o_head));
    dtf_host_model dtf_host_model_inst (.i_clk(i_clk), .i_rdata(o_rdata), .o_cs(i_cs),
        .o_addr(i_addr), .o_rd(i_rd), .o_wr(i_wr), .o_wdata(i_wdata));

    task automatic final_report;
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] stat();
        return {m_busy, i_unit_ready_flag, i_write_fault_flag, i_seek_done_flag,
                i_transfer_request_flag, 2'h0, m_err};
    endfunction : stat

    // reads while busy give status; error-register reads compare only the abort bit
    task automatic chk_rd(input logic [2:0] a);
        logic [7:0] e;
        dtf_host_model_inst.read_reg(a, rb);
        case (a)
            3'h2: e = cnt[7:0];
            3'h3: e = sec[7:0];
            3'h4: e = clo[7:0];
            3'h5: e = chi[7:0];
            3'h6: e = hd[7:0] | 8'hA0;
            default: e = stat();
        endcase
        if (m_busy) e = stat();
        if (a == 3'h1 && !m_busy) chk(rb & 8'h04, {m_abrt, 2'h0});
        else chk(rb, e);
        if (a == 3'h7) m_irq = 1'b0;
    endtask : chk_rd

    task automatic ports();
        chk(o_transfer_total, (cnt == 0) ? 256 : cnt);
        chk(o_lba_addr, {hd[3:0], chi[7:0], clo[7:0], sec[7:0]});
        chk({o_linear_block_mode, o_unit_select, o_head}, {hd[6], hd[4], hd[3:0]});
    endtask : ports

    task automatic cmd(input logic [7:0] op, input logic ok);
        dtf_host_model_inst.command(cnt[7:0], sec[7:0], clo[7:0], chi[7:0], hd[7:0], op);
        #1;
        chk({o_cmd_start, o_busy}, {ok, ok});
        {m_busy, m_err, m_abrt, m_irq} = {ok, !ok, !ok, !ok};
        chk(o_irq, m_irq);
        if (ok) chk(o_cmd_opcode, op);
        else chk_rd(3'h1);
    endtask : cmd

    task automatic sect();
        @(posedge i_clk) i_sector_done <= 1'b1;
        @(posedge i_clk) i_sector_done <= 1'b0;
        #1;
        cnt = (cnt - 1) & 255;
        if (hd[6]) begin
            la = ((hd & 15) << 24 | chi << 16 | clo << 8 | sec) + 1;
            {sec, clo, chi} = {la & 255, (la >> 8) & 255, (la >> 16) & 255};
        end else sec = (sec + 1) & 255;
        ports();
    endtask : sect

    task automatic fin(input logic err);
        @(posedge i_clk) {i_cmd_done, i_cmd_error} <= {1'b1, err};
        @(posedge i_clk) i_cmd_done <= 1'b0;
        #1;
        {m_busy, m_irq, m_err} = {1'b0, 1'b1, err};
        chk({o_busy, o_irq}, 2'h1);
    endtask : fin

    initial begin
        seed = $urandom(32'h8BE0);
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int a = 2; a < 8; a++) chk_rd(a[2:0]);
        @(posedge i_clk) i_init_done <= 1'b1;
        @(posedge i_clk) i_init_done <= 1'b0;
        m_busy = 1'b0;
        dtf_host_model_inst.read_reg(3'h1, rb);
        chk(rb, 8'h01);
        for (int a = 2; a < 8; a++) chk_rd(a[2:0]);
        ports();
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            {i_seek_done_flag, i_transfer_request_flag} <= 2'($urandom);
            cnt = (i == 0) ? 0 : ($urandom & 255);
            {sec, clo, chi, hd} = {$urandom & 255, $urandom & 255, $urandom & 255, $urandom & 95};
            dtf_host_model_inst.load(cnt[7:0], sec[7:0], clo[7:0], chi[7:0], hd[7:0]);
            ports();
            for (int a = 2; a < 8; a++) chk_rd(a[2:0]);
        end
        $display("test parameters done");
        cnt = 2;
        sec = 255;
        hd = 3;
        cmd(8'h30, 1'b1);
        chk_rd(3'h2);
        dtf_host_model_inst.write_reg(3'h2, 8'h55);
        sect();
        sect();
        fin(1'b1);
        chk_rd(3'h7);
        #1;
        chk(o_irq, 1'b0);
        chk_rd(3'h2);
        $display("test chs transfer done");
        cnt = 5;
        sec = 255;
        clo = 255;
        chi = 18;
        hd = 8'h45;
        cmd(8'h30, 1'b1);
        sect();
        fin(1'b0);
        cmd(8'hEC, 1'b0);
        chk_rd(3'h7);
        $display("test linear mode done");
        hd = $urandom & 31;
        foreach (good_ops[i]) begin
            cmd(good_ops[i], 1'b1);
            fin(1'b0);
        end
        foreach (bad_ops[i]) cmd(bad_ops[i], 1'b0);
        chk_rd(3'h7);
        $display("test opcode table done");
        @(posedge i_clk) i_unit_ready_flag <= 1'b0;
        cmd(8'h30, 1'b0);
        @(posedge i_clk) {i_unit_ready_flag, i_write_fault_flag} <= 2'h3;
        cmd(8'hC5, 1'b0);
        chk_rd(3'h7);
        @(posedge i_clk) i_write_fault_flag <= 1'b0;
        cmd(8'h31, 1'b1);
        fin(1'b0);
        $display("test not ready and fault done");
        final_report();
    end
endmodule : testbench
